// ---- dv/test_vectored_interrupt_control.sv ----
// testbench for the interrupt control block
// assumes core stand-in and checker beside the design
`timescale 1ns/1ps
`default_nettype none
module test_vectored_interrupt_control;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, tmr = 0, ext = 0;
  logic [7:0] addr = 0, pchg = 0, pevt = 0;
  logic [31:0] wdata = 0, rdata, prdata;
  logic pready, pslverr, req, tick, irq, ret;
  logic [14:0] vec;
  viv_pkg::viv_core_cmd_s cmd;
  int n_mismatch = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  viv_irq_ctrl dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_timer_zero_ovf(tmr), .i_ext_irq_pin(ext), .i_port_change_flags(pchg),
    .i_periph_evt(pevt), .i_return_instr(ret), .o_core_cmd(cmd), .o_vector(vec),
    .o_core_req(req), .o_insn_tick(tick), .o_irq(irq));
  viv_core_model u_core (.i_sys_clk(clk), .i_rst_b(rst_b), .i_cmd(cmd), .o_return_instr(ret));
  task automatic give_verdict;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  // sel 0 waits for load_pc, 1 for pop_pc
  task automatic wait_cmd(input logic sel, output int n);
    n = 0;
    while ((sel ? cmd.pop_pc : cmd.load_pc) !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n < 100}, 32'h1);
  endtask
  task automatic tmr_pulse;
    @(posedge clk) tmr <= 1'b1;
    @(posedge clk) tmr <= 1'b0;
  endtask
  task automatic s_reset;
    rd(viv_pkg::OFS_CTRL, 32'h01);
    rd(viv_pkg::OFS_FLAGS0, 32'h00);
    rd(8'h20, 32'h00);
    chk({31'h0, pslverr}, 32'h1);
  endtask
  task automatic s_flags;
    tmr_pulse();
    @(posedge clk) ext <= 1'b1;
    pchg <= 8'h04;
    rd(viv_pkg::OFS_FLAGS0, 32'h31);
    chk({31'h0, req}, 32'h0);
    wr(viv_pkg::OFS_FLAGS0, 32'hff);
    rd(viv_pkg::OFS_FLAGS0, 32'h10);
    pchg <= 8'h00;
    wr(viv_pkg::OFS_CTRL, 32'h00);
    ext <= 1'b0;
    rd(viv_pkg::OFS_FLAGS0, 32'h01);
    wr(viv_pkg::OFS_FLAGS0, 32'h01);
    rd(viv_pkg::OFS_FLAGS0, 32'h00);
  endtask
  task automatic s_periph;
    int n;
    wr(viv_pkg::OFS_EVT_MASK, 32'h01);
    wr(viv_pkg::OFS_CTRL, 32'h81);
    wr(viv_pkg::OFS_PEN, 32'h01);
    @(posedge clk) pevt <= 8'h01;
    @(posedge clk) pevt <= 8'h00;
    rd(viv_pkg::OFS_PFLAGS, 32'h01);
    chk({31'h0, req}, 32'h0);
    wr(viv_pkg::OFS_CTRL, 32'hc1);
    wait_cmd(1'b0, n);
    @(posedge clk);
    chk({17'h0, vec}, 32'h4);
    chk({31'h0, irq}, 32'h1);
    rd(viv_pkg::OFS_CTRL, 32'h41);
    wr(viv_pkg::OFS_PFLAGS, 32'h01);
    wr(viv_pkg::OFS_EVT_STAT, 32'h01);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    wait_cmd(1'b1, n);
    rd(viv_pkg::OFS_CTRL, 32'hc1);
    rd(viv_pkg::OFS_EVT_STAT, 32'h02);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic s_pending;
    int n;
    wr(viv_pkg::OFS_CTRL, 32'h41);
    wr(viv_pkg::OFS_EN0, 32'h20);
    tmr_pulse();
    repeat (8) @(posedge clk);
    chk({31'h0, req}, 32'h0);
    wr(viv_pkg::OFS_CTRL, 32'hc1);
    wait_cmd(1'b0, n);
    chk({31'h0, n < 20}, 32'h1);
    wr(viv_pkg::OFS_FLAGS0, 32'h20);
    wait_cmd(1'b1, n);
    tmr_pulse();
    wait_cmd(1'b0, n);
    chk({31'h0, n <= 4 * viv_pkg::CLK_PER_INSN}, 32'h1);
    wr(viv_pkg::OFS_FLAGS0, 32'h20);
    wait_cmd(1'b1, n);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    s_reset();
    s_flags();
    s_periph();
    s_pending();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
bind viv_irq_ctrl viv_irq_ctrl_properties u_props (.i_sys_clk, .i_rst_b, .i_return_instr,
  .o_core_cmd, .o_vector, .o_core_req, .o_insn_tick, .o_pslverr);
`default_nettype wire

// ---- dv/viv_core_model.sv ----
// processor core stand-in: returns from the service routine
// assumes o_core_cmd pulses of viv_irq_ctrl
`timescale 1ns/1ps
`default_nettype none
module viv_core_model
#(
  parameter int RET_DLY = 60
)
(
  // clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_b,
  // command link
  input  wire viv_pkg::viv_core_cmd_s i_cmd,
  output logic                        o_return_instr
);
  int cnt;
  // long routine leaves software time to clear its flags
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt <= 0;
      o_return_instr <= 1'b0;
    end
    else
    begin
      o_return_instr <= (cnt == 1);
      if (i_cmd.load_pc)
        cnt <= RET_DLY;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ---- dv/viv_irq_ctrl_properties.sv ----
// checker for the interrupt control block
// assumes bind onto viv_irq_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module viv_irq_ctrl_properties
(
  // clock and reset
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst_b,
  // core side and apb error
  input wire logic                   i_return_instr,
  input wire viv_pkg::viv_core_cmd_s o_core_cmd,
  input wire logic [14:0]            o_vector,
  input wire logic                   o_core_req,
  input wire logic                   o_insn_tick,
  input wire logic                   o_pslverr
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  AST_RST_NO_REQ: assert property ($rose(i_rst_b) |-> !o_core_req)
    else $error("request right after reset");
  AST_ACCEPT: assert property (o_insn_tick && o_core_req |=> o_core_cmd.flush)
    else $error("enabled request not accepted");
  AST_GIE_CLR: assert property (o_core_cmd.flush |-> !o_core_req)
    else $error("global enable kept on entry");
  AST_PUSH: assert property (o_core_cmd.flush |-> ##4 o_core_cmd.push_pc && o_core_cmd.save_ctx)
    else $error("no push or save after flush");
  AST_LOAD: assert property (o_core_cmd.flush |-> ##8 o_core_cmd.load_pc ##1 o_vector == viv_pkg::IRQ_VECTOR)
    else $error("vector not loaded");
  AST_LATENCY: assert property ($rose(o_core_req) |-> ##[1:16] o_core_cmd.load_pc)
    else $error("entry too slow");
  AST_RETURN: assert property (i_return_instr |=> o_core_cmd.pop_pc && o_core_cmd.restore_ctx)
    else $error("return not carried out");
  AST_PULSE: assert property (o_core_cmd.flush |=> !o_core_cmd.flush)
    else $error("flush longer than one clock");
  AST_TICK: assert property (o_insn_tick |=> !o_insn_tick [*3] ##1 o_insn_tick)
    else $error("instruction cycle not four clocks");
  cover property (o_core_cmd.flush);
  cover property (o_core_cmd.pop_pc);
  cover property (o_pslverr);
endmodule
`default_nettype wire

// ---- logic/viv_irq_ctrl.sv ----
// vectored interrupt control: flags, enables, entry and return sequencing
// assumes synchronous inputs, apb3 master, core acts on o_core_cmd pulses
// Notes on behaviour
// RULE_01: any reset clears global and peripheral group enables.
// RULE_02: redirect needs global enable, own enable, and group enable for peripherals.
// RULE_03: flags set by hardware whatever the enables hold.
// RULE_04: entry flushes, clears global enable, pushes pc, saves context, loads 0004.
// RULE_05: global enable clear only records; pending flag taken once it is set.
// RULE_06: return pops pc, restores context and sets global enable together.
// RULE_07: event to first vector instruction takes three or four instruction cycles.
// RULE_08: software polls flags and clears serviced ones before returning.
// RULE_09: software clears a flag before setting its enable.
// RULE_10: timer zero flag set on overflow, resets zero, held until cleared.
// RULE_11: pin change summary is read-only or of all port change flags.
// RULE_12: external flag set on the input event, held until cleared.
// RULE_13: flag zero bits 7,6,3,2,1 read as zero.
// RULE_14: request is global enable and any enabled flag, evaluated per instruction cycle.
`timescale 1ns/1ps
`default_nettype none

module viv_irq_ctrl
(
  // clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_b,
  // apb slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [7:0]            i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  output logic [31:0]                o_prdata,
  // event sources
  input  wire logic                  i_timer_zero_ovf,
  input  wire logic                  i_ext_irq_pin,
  input  wire logic [7:0]            i_port_change_flags,
  input  wire logic [7:0]            i_periph_evt,
  // processor core
  input  wire logic                  i_return_instr,
  output viv_pkg::viv_core_cmd_s     o_core_cmd,
  output logic [14:0]                o_vector,
  output logic                       o_core_req,
  output logic                       o_insn_tick,
  // interrupt line
  output logic                       o_irq
);

  logic [1:0]            q_cnt;
  logic                  insn_tick;
  viv_pkg::viv_state_e   state;
  viv_pkg::viv_state_e   next_state;
  logic                  global_irq_enable;
  logic                  periph_group_irq_enable;
  logic                  ext_edge_rising;
  logic                  timer_zero_overflow_flag;
  logic                  ext_irq_flag;
  logic                  pin_change_summary_flag;
  logic [7:0]            irq_enable_zero;
  logic [7:0]            periph_flag_regs;
  logic [7:0]            periph_enable_regs;
  logic [1:0]            evt_stat;
  logic [1:0]            evt_mask;
  logic                  ext_pin_d;
  logic                  ext_evt;
  logic                  setup;
  logic                  wr;
  logic                  core_req;
  logic                  accept;
  logic                  ret;
  logic [7:0]            flags0;
  logic [7:0]            wbyte;
  logic                  mapped;
  logic [31:0]           rd_mux;
  logic                  ext_primed;
  logic                  clr_flags0;
  logic                  clr_pflags;
  logic                  clr_evt_stat;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // write-one-clear with the hardware set taking priority
  function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
    sticky_next = set | (cur & ~clr);
  endfunction

  assign setup     = i_psel & ~i_penable;
  assign wr        = i_psel & i_penable & i_pwrite;
  assign wbyte     = i_pwdata[7:0];
  assign o_pready  = 1'b1;
  assign insn_tick = (q_cnt == viv_pkg::INSN_LAST);
  assign o_insn_tick = insn_tick;
  assign ret       = i_return_instr;

  // register write strobes shared by the write-one-clear bits
  assign clr_flags0   = wr & hit(i_paddr, viv_pkg::OFS_FLAGS0);
  assign clr_pflags   = wr & hit(i_paddr, viv_pkg::OFS_PFLAGS);
  assign clr_evt_stat = wr & hit(i_paddr, viv_pkg::OFS_EVT_STAT);

  // instruction cycle divider
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      q_cnt <= 2'h0;
    else
      q_cnt <= q_cnt + 2'h1;
  end

  // external input delay, primed one clock after reset
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ext_pin_d  <= 1'b0;
      ext_primed <= 1'b0;
    end
    else
    begin
      ext_pin_d  <= i_ext_irq_pin;
      ext_primed <= 1'b1;
    end
  end

  // no false edge from a pin already high at reset release
  always_comb
  begin
    ext_evt = 1'b0;
    if (ext_primed)
    begin
      if (ext_edge_rising)
        ext_evt = i_ext_irq_pin & ~ext_pin_d;
      else
        ext_evt = ~i_ext_irq_pin & ext_pin_d;
    end
  end

  // summary is combinational so it clears only when every port flag is clear
  assign pin_change_summary_flag = |i_port_change_flags; // RULE_11

  always_comb
  begin
    flags0                     = 8'h00; // RULE_13
    flags0[viv_pkg::BIT_TMR0]  = timer_zero_overflow_flag;
    flags0[viv_pkg::BIT_PCHG]  = pin_change_summary_flag;
    flags0[viv_pkg::BIT_EXT]   = ext_irq_flag;
  end

  // flag zero bits: set wins over a write-one clear
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      timer_zero_overflow_flag <= 1'b0; // RULE_10
      ext_irq_flag             <= 1'b0;
    end
    else
    begin
      timer_zero_overflow_flag <= sticky_next(timer_zero_overflow_flag, i_timer_zero_ovf, // RULE_03 RULE_10
        clr_flags0 & wbyte[viv_pkg::BIT_TMR0]);
      ext_irq_flag <= sticky_next(ext_irq_flag, ext_evt, clr_flags0 & wbyte[viv_pkg::BIT_EXT]); // RULE_03 RULE_12
    end
  end

  // peripheral flags, one per source
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_pflag
      always_ff @(posedge i_sys_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          periph_flag_regs[g] <= 1'b0;
        else
          periph_flag_regs[g] <= sticky_next(periph_flag_regs[g], i_periph_evt[g], clr_pflags & wbyte[g]); // RULE_03
      end
    end
  endgenerate

  // enable registers
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      irq_enable_zero    <= viv_pkg::RST_ZERO8;
      periph_enable_regs <= viv_pkg::RST_ZERO8;
    end
    else if (wr)
    begin
      if (hit(i_paddr, viv_pkg::OFS_EN0))
        irq_enable_zero <= wbyte & viv_pkg::FLAGS0_IMPL;
      if (hit(i_paddr, viv_pkg::OFS_PEN))
        periph_enable_regs <= wbyte;
    end
  end

  // edge select for the external input, rising after reset
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      ext_edge_rising <= viv_pkg::RST_CTRL[viv_pkg::BIT_EDGE];
    else if (wr && hit(i_paddr, viv_pkg::OFS_CTRL))
      ext_edge_rising <= wbyte[viv_pkg::BIT_EDGE];
  end

  // global enable: entry clears, return sets, else software writes
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      global_irq_enable <= viv_pkg::RST_CTRL[viv_pkg::BIT_GLB_EN]; // RULE_01
    else if (accept)
      global_irq_enable <= 1'b0; // RULE_04
    else if (ret)
      global_irq_enable <= 1'b1; // RULE_06
    else if (wr && hit(i_paddr, viv_pkg::OFS_CTRL))
      global_irq_enable <= wbyte[viv_pkg::BIT_GLB_EN];
  end

  // group enable is software only, no sequencing touches it
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      periph_group_irq_enable <= viv_pkg::RST_CTRL[viv_pkg::BIT_GRP_EN]; // RULE_01
    else if (wr && hit(i_paddr, viv_pkg::OFS_CTRL))
      periph_group_irq_enable <= wbyte[viv_pkg::BIT_GRP_EN];
  end

  // request: pending flags wait in their bits until global enable returns
  assign core_req = global_irq_enable // RULE_02 RULE_05 RULE_14
    & ((|(flags0 & irq_enable_zero))
    | (periph_group_irq_enable & (|(periph_flag_regs & periph_enable_regs))));
  assign o_core_req = core_req;

  // sampled only on the instruction boundary, as the core would
  assign accept = insn_tick & (state == viv_pkg::VIV_IDLE) & core_req; // RULE_14

  // entry sequence, one step per instruction cycle
  always_comb
  begin
    next_state = state;
    case (state)
      viv_pkg::VIV_IDLE:   if (accept) next_state = viv_pkg::VIV_FLUSH;
      viv_pkg::VIV_FLUSH:  if (insn_tick) next_state = viv_pkg::VIV_PUSH;
      viv_pkg::VIV_PUSH:   if (insn_tick) next_state = viv_pkg::VIV_VECTOR;
      viv_pkg::VIV_VECTOR: if (insn_tick) next_state = viv_pkg::VIV_IDLE;
      default:             next_state = viv_pkg::VIV_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      state <= viv_pkg::VIV_IDLE;
    else
      state <= next_state; // RULE_07
  end

  // core commands, one-cycle pulses from flops
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_core_cmd <= '0;
    else
    begin
      o_core_cmd.flush       <= accept; // RULE_04
      o_core_cmd.push_pc     <= insn_tick & (state == viv_pkg::VIV_FLUSH); // RULE_04
      o_core_cmd.save_ctx    <= insn_tick & (state == viv_pkg::VIV_FLUSH); // RULE_04
      o_core_cmd.load_pc     <= insn_tick & (state == viv_pkg::VIV_PUSH); // RULE_04 RULE_07
      o_core_cmd.pop_pc      <= ret; // RULE_06
      o_core_cmd.restore_ctx <= ret; // RULE_06
    end
  end

  // vector holds after entry so the core may sample it late
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_vector <= 15'h0000;
    else if (insn_tick && state == viv_pkg::VIV_PUSH)
      o_vector <= viv_pkg::IRQ_VECTOR; // RULE_04
  end

  // sticky event status, write one to clear, set wins
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      evt_stat <= 2'h0;
    else
    begin
      evt_stat[viv_pkg::BIT_EV_ENTRY]  <= sticky_next(evt_stat[viv_pkg::BIT_EV_ENTRY], accept,
        clr_evt_stat & wbyte[viv_pkg::BIT_EV_ENTRY]);
      evt_stat[viv_pkg::BIT_EV_RETURN] <= sticky_next(evt_stat[viv_pkg::BIT_EV_RETURN], ret,
        clr_evt_stat & wbyte[viv_pkg::BIT_EV_RETURN]);
    end
  end

  // event mask
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      evt_mask <= 2'h0;
    else if (wr && hit(i_paddr, viv_pkg::OFS_EVT_MASK))
      evt_mask <= wbyte[1:0];
  end

  assign o_irq = |(evt_stat & evt_mask);

  // read mux; unmapped reads zero with an error
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    case (i_paddr)
      viv_pkg::OFS_CTRL:
      begin
        rd_mux[viv_pkg::BIT_GLB_EN] = global_irq_enable;
        rd_mux[viv_pkg::BIT_GRP_EN] = periph_group_irq_enable;
        rd_mux[viv_pkg::BIT_EDGE] = ext_edge_rising;
      end
      viv_pkg::OFS_FLAGS0:     rd_mux[7:0] = flags0;
      viv_pkg::OFS_EN0:        rd_mux[7:0] = irq_enable_zero;
      viv_pkg::OFS_PFLAGS:     rd_mux[7:0] = periph_flag_regs;
      viv_pkg::OFS_PEN:        rd_mux[7:0] = periph_enable_regs;
      viv_pkg::OFS_CORE_STATE: rd_mux[2:0] = {core_req, state};
      viv_pkg::OFS_EVT_STAT:   rd_mux[1:0] = evt_stat;
      viv_pkg::OFS_EVT_MASK:   rd_mux[1:0] = evt_mask;
      default:                 mapped = 1'b0;
    endcase
  end

  // read data captured at setup, stands through the access phase
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (setup)
    begin
      o_prdata  <= rd_mux;
      o_pslverr <= ~mapped;
    end
  end

endmodule

`default_nettype wire

// ---- logic/viv_pkg.sv ----
// package for the vectored interrupt control block
// assumes one 200 MHz system clock and an apb3 register port
package viv_pkg;

  // apb byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_FLAGS0     = 8'h04;
  localparam logic [7:0] OFS_EN0        = 8'h08;
  localparam logic [7:0] OFS_PFLAGS     = 8'h0c;
  localparam logic [7:0] OFS_PEN        = 8'h10;
  localparam logic [7:0] OFS_CORE_STATE = 8'h14;
  localparam logic [7:0] OFS_EVT_STAT   = 8'h18;
  localparam logic [7:0] OFS_EVT_MASK   = 8'h1c;

  // control register fields
  localparam int BIT_GLB_EN = 7;
  localparam int BIT_GRP_EN = 6;
  localparam int BIT_EDGE   = 0;

  // flag register zero fields
  localparam int BIT_TMR0   = 5;
  localparam int BIT_PCHG   = 4;
  localparam int BIT_EXT    = 0;
  localparam logic [7:0] FLAGS0_IMPL = 8'h31;

  // event status fields
  localparam int BIT_EV_ENTRY  = 0;
  localparam int BIT_EV_RETURN = 1;

  // reset values
  localparam logic [7:0] RST_CTRL  = 8'h01;
  localparam logic [7:0] RST_ZERO8 = 8'h00;

  // fixed vector and instruction cycle
  localparam logic [14:0] IRQ_VECTOR   = 15'h0004;
  localparam int          CLK_PER_INSN = 4;
  localparam logic [1:0]  INSN_LAST    = 2'(CLK_PER_INSN - 1);

  typedef enum logic [1:0] {
    VIV_IDLE,
    VIV_FLUSH,
    VIV_PUSH,
    VIV_VECTOR
  } viv_state_e;

  // commands to the processor core
  typedef struct packed {
    logic flush;
    logic push_pc;
    logic save_ctx;
    logic load_pc;
    logic pop_pc;
    logic restore_ctx;
  } viv_core_cmd_s;

endpackage
